/* hw/pcp_pkg.sv */
package pcp_pkg;
  // Register byte addresses
  localparam logic [31:0] PCP_MODE_ADDR    = 32'h400e0f50;
  localparam logic [31:0] PCP_IER_ADDR     = 32'h400e0f54;
  localparam logic [31:0] PCP_IDR_ADDR     = 32'h400e0f58;
  localparam logic [31:0] PCP_IMR_ADDR     = 32'h400e0f5c;
  localparam logic [31:0] PCP_STATUS_ADDR  = 32'h400e0f60;
  localparam logic [31:0] PCP_HOLD_ADDR    = 32'h400e0f64;
  localparam logic [31:0] PCP_WPROT_ADDR   = 32'h400e0f68;
  // Mode register fields
  localparam int PCP_EN_BIT     = 0;
  localparam int PCP_SIZE_LSB   = 4;
  localparam int PCP_IGNORE_BIT = 9;
  localparam int PCP_HALF_BIT   = 10;
  localparam int PCP_ODD_BIT    = 11;
  // Status, enable, disable and mask share this layout
  localparam int PCP_CAPTURE_DATA_READY_BIT   = 0;
  localparam int PCP_OVR_BIT    = 1;
  localparam int PCP_DMA_END_OF_RECEIVE_BIT  = 2;
  localparam int PCP_FULL_BIT   = 3;
  localparam int PCP_WP_BIT     = 0;
  localparam int PCP_IRQ_W      = 4;
  // Word size codes
  localparam logic [1:0] PCP_SIZE_BYTE = 2'h0;
  localparam logic [1:0] PCP_SIZE_HALF = 2'h1;
  localparam logic [1:0] PCP_SIZE_WORD = 2'h2;
  // Values after reset, then data and word widths
  localparam logic [31:0] PCP_MODE_RST = 32'h00000000;
  localparam logic [3:0]  PCP_MASK_RST = 4'h0;
  localparam int PCP_DATA_W = 8;
  localparam int PCP_WORD_W = 32;
  // Bus handshake states
  typedef enum logic [1:0] {PCP_BUS_IDLE, PCP_BUS_ANSWER} pcp_bus_type;
endpackage

/* hw/pcp_cfg_if.sv */
`timescale 1ns/1ps
interface pcp_cfg_if;
  logic        enable;      // Capture running
  logic [1:0]  size;        // Word size code
  logic        ignore;      // Sample regardless of qualifiers
  logic        half;        // Keep one sample of two
  logic        odd;         // Keep odd-indexed samples
  logic [31:0] word;        // Completed word
  logic        word_valid;  // One-cycle pulse per word
  modport ctl (output enable, size, ignore, half, odd, input word, word_valid);
  modport smp (input enable, size, ignore, half, odd, output word, word_valid);
endinterface

/* hw/pcp_sampler.sv */
`timescale 1ns/1ps
module pcp_sampler import pcp_pkg::*; #(
  parameter int DATA_W = PCP_DATA_W
) (
  input  logic              clock,     // System clock
  input  logic              sys_rst,   // Synchronous reset
  input  logic              cap_clk,   // Sampling clock pin
  input  logic [DATA_W-1:0] cap_data,  // Parallel data pins
  input  logic              cap_den1,  // First data qualifier
  input  logic              cap_den2,  // Second data qualifier
  pcp_cfg_if.smp            cfg        // Settings in, words out
);
  localparam int SW = DATA_W + 3;
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic          clk_prev_r;
  logic          idx_r;
  logic [1:0]    cnt_r;
  logic [31:0]   buf_r;
  logic [31:0]   word_r;
  logic          valid_r;
  logic          edge_seen;
  logic          qual;
  logic          keep;
  logic [31:0]   buf_nxt;

  // Last lane index for a size code; reserved code packs a full word
  function automatic logic [1:0] last_lane(input logic [1:0] size);
    case (size)
      PCP_SIZE_BYTE: last_lane = 2'h0;
      PCP_SIZE_HALF: last_lane = 2'h1;
      default:       last_lane = 2'h3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; data rides with its clock to stay aligned
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_r       <= '0;
      s2_r       <= '0;
      clk_prev_r <= 1'b0;
    end else begin
      s1_r       <= {cap_clk, cap_den1, cap_den2, cap_data};
      s2_r       <= s1_r;
      clk_prev_r <= s2_r[SW-1];
    end
  end

  // Sample point is the rising edge of the pin clock
  assign edge_seen = s2_r[SW-1] & ~clk_prev_r;
  assign qual = edge_seen & cfg.enable & (cfg.ignore | (s2_r[DATA_W+1] & s2_r[DATA_W]));
  assign keep = qual & (~cfg.half | (idx_r == cfg.odd));

  // Sample index parity, counted over qualified samples only
  always_ff @(posedge clock) begin
    if (sys_rst || !cfg.enable) begin
      idx_r <= 1'b0;
    end else if (qual) begin
      idx_r <= ~idx_r;
    end
  end

  // Arrival order fills lanes from the low byte upward
  always_comb begin
    buf_nxt = buf_r;
    buf_nxt[cnt_r*DATA_W +: DATA_W] = s2_r[DATA_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Packer; unused upper lanes stay zero for narrow sizes
  always_ff @(posedge clock) begin
    if (sys_rst || !cfg.enable) begin
      cnt_r   <= 2'h0;
      buf_r   <= '0;
      word_r  <= '0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      if (keep && cnt_r == last_lane(cfg.size)) begin
        word_r  <= buf_nxt;
        buf_r   <= '0;
        cnt_r   <= 2'h0;
        valid_r <= 1'b1;
      end else if (keep) begin
        buf_r <= buf_nxt;
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end

  assign cfg.word       = word_r;
  assign cfg.word_valid = valid_r;

  property p_qual_gate;
    @(posedge clock) disable iff (sys_rst)
    qual |-> cfg.enable && (cfg.ignore || (s2_r[DATA_W+1] && s2_r[DATA_W]));
  endproperty
  a_qual_gate: assert property (p_qual_gate) else $error("sample taken without qualifiers");

  property p_half_pick;
    @(posedge clock) disable iff (sys_rst)
    keep && cfg.half |-> idx_r == cfg.odd;
  endproperty
  a_half_pick: assert property (p_half_pick) else $error("wrong half-rate sample kept");
endmodule

/* hw/pcp_top.sv */
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module pcp_top import pcp_pkg::*; #(
  parameter int DATA_W = PCP_DATA_W
) (
  input  logic              clock,                // System clock
  input  logic              sys_rst,              // Synchronous reset
  input  logic [31:0]       address,              // Byte address
  input  logic              read,                 // Read request
  input  logic              write,                // Write request
  input  logic [31:0]       writedata,            // Write data
  input  logic [3:0]        byteenable,           // Write lanes
  output logic [31:0]       readdata,             // Read data
  output logic              waitrequest,          // Hold off master
  output logic              irq,                  // Level interrupt
  output logic              dma_rx_request,       // Word waiting for DMA
  input  logic              dma_end_of_receive,   // DMA end of transfer
  input  logic              dma_buffer_full,      // DMA buffer full
  input  logic              cap_clk,              // Sampling clock pin
  input  logic [DATA_W-1:0] cap_data,             // Parallel data pins
  input  logic              cap_den1,             // First qualifier pin
  input  logic              cap_den2              // Second qualifier pin
);
  pcp_cfg_if cfg ();

  pcp_bus_type bus_r;
  logic [31:0] readdata_r;
  logic        waitrequest_r;
  logic [31:0] mode_r;
  logic        wp_r;
  logic [3:0]  mask_r;
  logic        capture_data_ready_r;
  logic        ovr_r;
  logic        dma_end_of_receive_r;
  logic        full_r;
  logic [31:0] hold_r;
  logic        irq_r;
  logic        req;
  logic        acc;
  logic        acc_wr;
  logic        acc_rd;
  logic [31:0] wd;
  logic [3:0]  status;
  logic [31:0] rd_nxt;

  // Expand byte enables into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Address match shared by every decode below
  function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
    hit = (a == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sampler and packer
  pcp_sampler #(
    .DATA_W (DATA_W)
  ) u_sampler (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .cap_clk  (cap_clk),
    .cap_data (cap_data),
    .cap_den1 (cap_den1),
    .cap_den2 (cap_den2),
    .cfg      (cfg)
  );

  // Settings straight from the mode register
  assign cfg.enable = mode_r[PCP_EN_BIT];
  assign cfg.size   = mode_r[PCP_SIZE_LSB +: 2];
  assign cfg.ignore = mode_r[PCP_IGNORE_BIT];
  assign cfg.half   = mode_r[PCP_HALF_BIT];
  assign cfg.odd    = mode_r[PCP_ODD_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the access is taken
  assign req    = read | write;
  assign acc    = req & (bus_r == PCP_BUS_ANSWER);
  assign acc_wr = acc & write;
  assign acc_rd = acc & read;
  assign wd     = writedata & lane_mask(byteenable);
  assign status = {full_r, dma_end_of_receive_r, ovr_r, capture_data_ready_r};

  // Read mux; unmapped and write-only addresses read zero
  always_comb begin
    rd_nxt = 32'h00000000;
    if (hit(address, PCP_MODE_ADDR)) begin
      rd_nxt = mode_r;
    end else if (hit(address, PCP_IMR_ADDR)) begin
      rd_nxt = {28'h0000000, mask_r};
    end else if (hit(address, PCP_STATUS_ADDR)) begin
      rd_nxt = {28'h0000000, status};
    end else if (hit(address, PCP_HOLD_ADDR)) begin
      rd_nxt = hold_r;
    end else if (hit(address, PCP_WPROT_ADDR)) begin
      rd_nxt = {31'h00000000, wp_r};
    end
  end

  // Handshake state; read data is latched while waitrequest is high
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_r         <= PCP_BUS_IDLE;
      readdata_r    <= 32'h00000000;
      waitrequest_r <= 1'b1;
    end else begin
      case (bus_r)
        PCP_BUS_IDLE: begin
          if (req) begin
            bus_r         <= PCP_BUS_ANSWER;
            readdata_r    <= rd_nxt;
            waitrequest_r <= 1'b0;
          end
        end
        PCP_BUS_ANSWER: begin
          bus_r         <= PCP_BUS_IDLE;
          waitrequest_r <= 1'b1;
        end
        default: begin
          bus_r         <= PCP_BUS_IDLE;
          waitrequest_r <= 1'b1;
        end
      endcase
    end
  end

  assign readdata    = readdata_r;
  assign waitrequest = waitrequest_r;

  ////////////////////////////////////////////////////////////////////////
  // Mode and write protect registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_r <= PCP_MODE_RST;
    end else if (acc_wr && hit(address, PCP_MODE_ADDR) && !wp_r) begin
      mode_r <= (mode_r & ~lane_mask(byteenable)) | (wd & 32'h00000e31);
    end
  end

  // Protection stays settable after reset so software can lock early
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wp_r <= 1'b0;
    end else if (acc_wr && hit(address, PCP_WPROT_ADDR) && byteenable[0]) begin
      wp_r <= writedata[PCP_WP_BIT];
    end
  end

  // Interrupt mask: enable sets, disable clears
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask_r <= PCP_MASK_RST;
    end else if (acc_wr && hit(address, PCP_IER_ADDR)) begin
      mask_r <= mask_r | wd[3:0];
    end else if (acc_wr && hit(address, PCP_IDR_ADDR)) begin
      mask_r <= mask_r & ~wd[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Holding register always takes the newest word
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_r <= 32'h00000000;
    end else if (cfg.word_valid) begin
      hold_r <= cfg.word;
    end
  end

  // Data ready: a new word wins over a read in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst || !cfg.enable) begin
      capture_data_ready_r <= 1'b0;
    end else if (cfg.word_valid) begin
      capture_data_ready_r <= 1'b1;
    end else if (acc_rd && hit(address, PCP_HOLD_ADDR)) begin
      capture_data_ready_r <= 1'b0;
    end else if (acc_wr && hit(address, PCP_STATUS_ADDR) && wd[PCP_CAPTURE_DATA_READY_BIT]) begin
      capture_data_ready_r <= 1'b0;
    end
  end

  // Overrun: sticky until status read, write-one or disable
  always_ff @(posedge clock) begin
    if (sys_rst || !cfg.enable) begin
      ovr_r <= 1'b0;
    end else if (cfg.word_valid && capture_data_ready_r) begin
      ovr_r <= 1'b1;
    end else if (acc_rd && hit(address, PCP_STATUS_ADDR)) begin
      ovr_r <= 1'b0;
    end else if (acc_wr && hit(address, PCP_STATUS_ADDR) && wd[PCP_OVR_BIT]) begin
      ovr_r <= 1'b0;
    end
  end

  // DMA levels are mirrored, one register stage late
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dma_end_of_receive_r <= 1'b0;
      full_r  <= 1'b0;
    end else begin
      dma_end_of_receive_r <= dma_end_of_receive;
      full_r  <= dma_buffer_full;
    end
  end

  // Interrupt and DMA request come straight from flops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status & mask_r);
    end
  end

  assign irq            = irq_r;
  assign dma_rx_request = capture_data_ready_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_request_waits;
    req && waitrequest;
  endsequence

  sequence s_answered;
    !waitrequest ##1 waitrequest;
  endsequence

  property p_bus_answer;
    s_request_waits |=> s_answered;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not after one wait cycle");

  property p_off_idle;
    !cfg.enable |=> !capture_data_ready_r && !ovr_r;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("flags set while capture off");

  property p_byte_size;
    cfg.word_valid && cfg.size == PCP_SIZE_BYTE |=> hold_r[31:8] == 24'h000000;
  endproperty
  a_byte_size: assert property (p_byte_size) else $error("byte word has upper bits set");

  property p_half_size;
    cfg.word_valid && cfg.size == PCP_SIZE_HALF |=> hold_r[31:16] == 16'h0000;
  endproperty
  a_half_size: assert property (p_half_size) else $error("half word has upper bits set");

  property p_protect;
    acc_wr && hit(address, PCP_MODE_ADDR) && wp_r |=> $stable(mode_r);
  endproperty
  a_protect: assert property (p_protect) else $error("protected mode register changed");

  property p_ready_set;
    cfg.word_valid && cfg.enable |=> capture_data_ready_r && hold_r == $past(cfg.word);
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("new word not flagged ready");

  property p_ready_clear;
    acc_rd && hit(address, PCP_HOLD_ADDR) && !cfg.word_valid |=> !capture_data_ready_r;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared by holding read");

  property p_overrun;
    cfg.word_valid && capture_data_ready_r && cfg.enable |=> ovr_r;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_mirror;
    ##1 dma_end_of_receive_r == $past(dma_end_of_receive) && full_r == $past(dma_buffer_full);
  endproperty
  a_mirror: assert property (p_mirror) else $error("DMA status not mirrored");

  property p_mask_set;
    acc_wr && hit(address, PCP_IER_ADDR) && wd[PCP_CAPTURE_DATA_READY_BIT] |=> mask_r[PCP_CAPTURE_DATA_READY_BIT];
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("enable did not set mask");

  property p_mask_clear;
    acc_wr && hit(address, PCP_IDR_ADDR) && wd[PCP_FULL_BIT] |=> !mask_r[PCP_FULL_BIT];
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("disable did not clear mask");

  property p_irq;
    |(status & mask_r) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_irq_quiet;
    (status & mask_r) == 4'h0 |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("spurious interrupt");

  property p_ready_hold;
    capture_data_ready_r && cfg.enable && !(acc && (hit(address, PCP_HOLD_ADDR) || hit(address, PCP_STATUS_ADDR)))
      |=> capture_data_ready_r;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped without a read");

  property p_overrun_hold;
    ovr_r && cfg.enable && !(acc && hit(address, PCP_STATUS_ADDR)) |=> ovr_r;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("overrun dropped without a status read");

  property p_status_clear;
    acc_rd && hit(address, PCP_STATUS_ADDR) && !(cfg.word_valid && capture_data_ready_r) |=> !ovr_r;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("overrun not cleared by status read");

  property p_mask_read;
    acc_rd && hit(address, PCP_IMR_ADDR) |-> readdata == {28'h0000000, mask_r};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read back wrong");

  property p_off_no_word;
    !cfg.enable |=> !cfg.word_valid;
  endproperty
  a_off_no_word: assert property (p_off_no_word) else $error("word completed while capture off");

  property p_wait_idle;
    !req && waitrequest |=> waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest dropped with no request");
endmodule

/* dv/pcp_sensor_model.sv */
`timescale 1ns/1ps
//////////////////////////////
module pcp_sensor_model import pcp_pkg::*; (
  output logic                  cap_clk,   // Link clock, still between samples
  output logic [PCP_DATA_W-1:0] cap_data,  // Parallel data
  output logic                  cap_den1,  // First qualifier
  output logic                  cap_den2   // Second qualifier
);
  // Idle lines at power-up
  initial begin
    cap_clk = 1'b0;
    cap_data = '0;
    cap_den1 = 1'b0;
    cap_den2 = 1'b0;
  end
  // One sample per 80 ns clock period, phase unrelated to the system clock
  task automatic send(input logic [PCP_DATA_W-1:0] d, input logic q1, input logic q2);
    #3;
    cap_data = d;
    cap_den1 = q1;
    cap_den2 = q2;
    #20;
    cap_clk = 1'b1;
    #40;
    cap_clk = 1'b0;
    #17;
    // Inverse after hold, so stale data never passes for a match
    cap_data = ~d;
    cap_den1 = ~q1;
    cap_den2 = ~q2;
  endtask
endmodule

/* dv/tb_parallel_capture_port.sv */
`timescale 1ns/1ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("wrong value %0t %s", $time, m); end end
//////////////////////////////
module tb_parallel_capture_port import pcp_pkg::*; ;
  logic                  clock = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  read = 1'b0;
  logic                  write = 1'b0;
  logic [31:0]           address = '0;
  logic [31:0]           writedata = '0;
  logic [3:0]            byteenable = 4'hf;
  logic [31:0]           readdata;
  logic                  waitrequest;
  logic                  irq;
  logic                  dma_rx_request;
  logic                  dma_end_of_receive = 1'b0;
  logic                  dma_buffer_full = 1'b0;
  logic                  cap_clk;
  logic [PCP_DATA_W-1:0] cap_data;
  logic                  cap_den1;
  logic                  cap_den2;
  logic [31:0]           rd;
  int                    err_count = 0;
  int                    samples_checked = 0;

  // 125 MHz system clock
  always #4 clock = ~clock;

  pcp_top DUT (.clock(clock), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .dma_rx_request(dma_rx_request), .dma_end_of_receive(dma_end_of_receive),
    .dma_buffer_full(dma_buffer_full), .cap_clk(cap_clk), .cap_data(cap_data),
    .cap_den1(cap_den1), .cap_den2(cap_den2));
  pcp_sensor_model P (.cap_clk(cap_clk), .cap_data(cap_data), .cap_den1(cap_den1), .cap_den2(cap_den2));

  //////////////////////////////
  // One transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    // No local limit: only the watchdog ends a stalled transfer
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [31:0] mw(input logic en, input logic [1:0] sz, input logic ig, input logic hf,
                                     input logic od);
    logic [31:0] m;
    m = '0;
    m[PCP_EN_BIT] = en;
    m[PCP_SIZE_LSB+:2] = sz;
    m[PCP_IGNORE_BIT] = ig;
    m[PCP_HALF_BIT] = hf;
    m[PCP_ODD_BIT] = od;
    return m;
  endfunction
  // Bounded wait, since sync latency is only approximate
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (dma_rx_request !== 1'b1 && n < 30);
  endtask
  task automatic take(input logic [31:0] e);
    wait_rdy();
    `CHK(dma_rx_request, 1'b1, "no word")
    bus(1'b0, PCP_HOLD_ADDR, '0);
    `CHK(rd, e, "word")
    `CHK(dma_rx_request, 1'b0, "ready stuck")
  endtask
  task automatic quiet();
    repeat (12) @(posedge clock);
    `CHK(dma_rx_request, 1'b0, "sample kept")
  endtask

  //////////////////////////////
  task automatic t_reset();
    logic [31:0] a[6];
    a = '{PCP_MODE_ADDR, PCP_IMR_ADDR, PCP_STATUS_ADDR, PCP_HOLD_ADDR, PCP_IER_ADDR, 32'h400e0f70};
    foreach (a[i]) begin
      bus(1'b0, a[i], '0);
      `CHK(rd, 32'h0, "reset read")
    end
    `CHK(irq, 1'b0, "irq")
  endtask
  // Every size code, reserved one included, with packing order
  task automatic t_sizes();
    logic [31:0] e;
    logic [7:0]  d;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, PCP_MODE_ADDR, mw(1'b1, 2'(s), 1'b0, 1'b0, 1'b0));
      bus(1'b0, PCP_MODE_ADDR, '0);
      `CHK(rd, mw(1'b1, 2'(s), 1'b0, 1'b0, 1'b0), "mode")
      e = '0;
      for (int i = 0; i < (s == 0 ? 1 : s == 1 ? 2 : 4); i++) begin
        d = 8'(8'h1b + 8'h21 * i + s);
        P.send(d, 1'b1, 1'b1);
        e = e | (32'(d) << (8 * i));
      end
      take(e);
      bus(1'b1, PCP_MODE_ADDR, '0);
    end
  endtask
  task automatic t_qual();
    bus(1'b1, PCP_MODE_ADDR, mw(1'b1, 2'h0, 1'b0, 1'b0, 1'b0));
    P.send(8'ha5, 1'b1, 1'b0);
    P.send(8'h5a, 1'b0, 1'b1);
    quiet();
    P.send(8'h3c, 1'b1, 1'b1);
    take(32'h3c);
    bus(1'b1, PCP_MODE_ADDR, '0);
    P.send(8'h77, 1'b1, 1'b1);
    quiet();
    bus(1'b1, PCP_MODE_ADDR, mw(1'b1, 2'h0, 1'b1, 1'b0, 1'b0));
    P.send(8'hc3, 1'b0, 1'b0);
    take(32'hc3);
    bus(1'b1, PCP_MODE_ADDR, '0);
  endtask
  task automatic t_half();
    bus(1'b1, PCP_MODE_ADDR, mw(1'b1, 2'h0, 1'b0, 1'b1, 1'b0));
    P.send(8'h11, 1'b1, 1'b1);
    take(32'h11);
    P.send(8'h22, 1'b1, 1'b1);
    quiet();
    P.send(8'h33, 1'b1, 1'b1);
    take(32'h33);
    bus(1'b1, PCP_MODE_ADDR, '0);
    bus(1'b1, PCP_MODE_ADDR, mw(1'b1, 2'h0, 1'b1, 1'b1, 1'b1));
    P.send(8'h44, 1'b0, 1'b0);
    quiet();
    P.send(8'h55, 1'b0, 1'b0);
    take(32'h55);
    bus(1'b1, PCP_MODE_ADDR, '0);
  endtask
  // Second word before the first is read
  task automatic t_overrun();
    bus(1'b1, PCP_IER_ADDR, 32'h2);
    bus(1'b1, PCP_MODE_ADDR, mw(1'b1, 2'h0, 1'b0, 1'b0, 1'b0));
    P.send(8'h61, 1'b1, 1'b1);
    P.send(8'h62, 1'b1, 1'b1);
    wait_rdy();
    repeat (4) @(posedge clock);
    `CHK(irq, 1'b1, "irq ovr")
    bus(1'b0, PCP_STATUS_ADDR, '0);
    `CHK(rd, 32'h3, "ovr set")
    bus(1'b0, PCP_STATUS_ADDR, '0);
    `CHK(rd, 32'h1, "ovr clr")
    `CHK(irq, 1'b0, "irq clr")
    take(32'h62);
    P.send(8'h63, 1'b1, 1'b1);
    P.send(8'h64, 1'b1, 1'b1);
    wait_rdy();
    bus(1'b1, PCP_MODE_ADDR, '0);
    bus(1'b0, PCP_STATUS_ADDR, '0);
    `CHK(rd, 32'h0, "disable clr")
    bus(1'b1, PCP_IDR_ADDR, 32'h2);
  endtask
  task automatic t_wprot();
    bus(1'b1, PCP_WPROT_ADDR, 32'h1);
    bus(1'b1, PCP_MODE_ADDR, mw(1'b1, 2'h2, 1'b1, 1'b1, 1'b1));
    bus(1'b0, PCP_MODE_ADDR, '0);
    `CHK(rd, 32'h0, "locked")
    bus(1'b1, PCP_WPROT_ADDR, 32'h0);
    bus(1'b1, PCP_MODE_ADDR, mw(1'b0, 2'h2, 1'b1, 1'b1, 1'b1));
    bus(1'b0, PCP_MODE_ADDR, '0);
    `CHK(rd, mw(1'b0, 2'h2, 1'b1, 1'b1, 1'b1), "unlocked")
    bus(1'b1, PCP_MODE_ADDR, '0);
  endtask
  // DMA mirrors and mask set/clear
  task automatic t_dma_irq();
    bus(1'b1, PCP_IER_ADDR, 32'hf);
    bus(1'b0, PCP_IMR_ADDR, '0);
    `CHK(rd, 32'hf, "mask all")
    bus(1'b1, PCP_IDR_ADDR, 32'hb);
    bus(1'b0, PCP_IMR_ADDR, '0);
    `CHK(rd, 32'h4, "mask left")
    dma_end_of_receive <= 1'b1;
    dma_buffer_full <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b1, "irq end")
    bus(1'b0, PCP_STATUS_ADDR, '0);
    `CHK(rd, 32'hc, "mirrors")
    bus(1'b1, PCP_IDR_ADDR, 32'h4);
    @(posedge clock);
    `CHK(irq, 1'b0, "irq masked")
    bus(1'b1, PCP_IER_ADDR, 32'h8);
    @(posedge clock);
    `CHK(irq, 1'b1, "irq full")
    dma_buffer_full <= 1'b0;
    dma_end_of_receive <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b0, "irq follows")
    bus(1'b0, PCP_STATUS_ADDR, '0);
    `CHK(rd, 32'h0, "mirrors off")
  endtask

  //////////////////////////////
  task automatic conclude();
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_sizes();
    t_qual();
    t_half();
    t_overrun();
    t_wprot();
    t_dma_irq();
    conclude();
  end
  // Watchdog, well beyond the several hundred cycles needed
  initial begin
    #400000;
    err_count++;
    conclude();
  end
endmodule
